// [phyev_params.svh]
`ifndef PHYEV_PARAMS_SVH
`define PHYEV_PARAMS_SVH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define PHYEV_ADDR_STATUS      6'h13
`define PHYEV_ADDR_LATCH       6'h14
`define PHYEV_ADDR_DEBUG       6'h15
`define PHYEV_ADDR_SPARE_WR    6'h16
`define PHYEV_ADDR_SPARE_SET   6'h17
`define PHYEV_ADDR_SPARE_CLR   6'h18
`define PHYEV_ADDR_ACC_WR      6'h19
`define PHYEV_ADDR_ACC_SET     6'h1A
`define PHYEV_ADDR_ACC_CLR     6'h1B
`define PHYEV_ADDR_IEN_WR      6'h1D
`define PHYEV_ADDR_IEN_SET     6'h1E
`define PHYEV_ADDR_IEN_CLR     6'h1F

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PHYEV_CMP_HOST_DISC    0
`define PHYEV_CMP_BUS_VALID    1
`define PHYEV_CMP_SESS_VALID   2
`define PHYEV_CMP_SESS_END     3
`define PHYEV_CMP_ID_GND       4
`define PHYEV_ACC_ID_PULL_LOW  1
`define PHYEV_ACC_TX_ROUTE     2
`define PHYEV_ACC_RX_ROUTE     3
`define PHYEV_IEN_OPEN_RISE    0
`define PHYEV_IEN_OPEN_FALL    1
`define PHYEV_IEN_RID_DONE     5

// ---------------------------------------------------------------
// writable-bit masks and reset values
// ---------------------------------------------------------------
`define PHYEV_SPARE_KEEP       8'hFF
`define PHYEV_ACC_KEEP         8'h0E
`define PHYEV_IEN_KEEP         8'h23
`define PHYEV_SPARE_RESET      8'h00
`define PHYEV_ACC_RESET        8'h00
`define PHYEV_IEN_RESET        8'h00
`define PHYEV_BYTE_ZERO        8'h00

`endif

// [phyev_pkg.sv]
package phyev_pkg;

   // ---------------------------------------------------------------
   // shared types
   // ---------------------------------------------------------------
   typedef logic [5:0] phyev_addr_t;
   typedef logic [7:0] phyev_byte_t;
   typedef logic [4:0] phyev_cmp_t;

   // kind of write an address selects
   typedef enum logic [1:0] {
      PHYEV_WOP_NONE  = 2'b00,
      PHYEV_WOP_WRITE = 2'b01,
      PHYEV_WOP_SET   = 2'b10,
      PHYEV_WOP_CLEAR = 2'b11
   } phyev_wop_e;

endpackage

// [phyev_edge_if.sv]
`timescale 1ns/1ns

// edge-event bundle between register slice and edge latch
interface phyev_edge_if #(
   parameter int W = 1
);
   logic [W-1:0] level;
   logic [W-1:0] riseEn;
   logic [W-1:0] fallEn;
   logic         clearAll;
   logic [W-1:0] latched;
   logic [W-1:0] eventPulse;

   modport owner (
      input  level,
      input  riseEn,
      input  fallEn,
      input  clearAll,
      output latched,
      output eventPulse
   );

   modport user (
      output level,
      output riseEn,
      output fallEn,
      output clearAll,
      input  latched,
      input  eventPulse
   );
endinterface

// [phyev_edge_latch.sv]
`timescale 1ns/1ns

// per-bit edge detector with sticky latch and event pulse
module phyev_edge_latch #(
   parameter int W = 1
) (
   input wire logic     ref_clk,
   input wire logic     nrst,
   phyev_edge_if.owner  edges
);
   import phyev_pkg::*;

   logic         primed_q;
   logic [W-1:0] prev_q;
   logic [W-1:0] latch_q;
   logic [W-1:0] latch_d;
   logic [W-1:0] pulse_q;
   logic [W-1:0] events;

   // ---------------------------------------------------------------
   // edge qualification
   // ---------------------------------------------------------------
   // first cycle after reset only samples: a level already high at
   // release is a condition, not a change
   always_comb begin
      events = '0;
      if (primed_q) begin
         events = (edges.level & ~prev_q & edges.riseEn)
                | (~edges.level & prev_q & edges.fallEn);
      end
   end

   // sampler for the previous level
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prev_q   <= '0;
         primed_q <= 1'b0;
      end else begin
         prev_q   <= edges.level;
         primed_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // sticky latch: a new event beats the clear of the same cycle
   // ---------------------------------------------------------------
   always_comb begin
      latch_d = (latch_q & ~{W{edges.clearAll}}) | events;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         latch_q <= '0;
         pulse_q <= '0;
      end else begin
         latch_q <= latch_d;
         pulse_q <= events;
      end
   end

   assign edges.latched    = latch_q;
   assign edges.eventPulse = pulse_q;
endmodule

// [phyev_regs.sv]
`timescale 1ns/1ns
`include "phyev_params.svh"

module phyev_regs (
   input  wire logic               ref_clk,
   input  wire logic               nrst,
   // register port from the link-side protocol engine
   input  wire phyev_pkg::phyev_addr_t regAddr,
   input  wire phyev_pkg::phyev_byte_t regWrData,
   input  wire logic               regWrStrobe,
   input  wire logic               regRdStrobe,
   output      phyev_pkg::phyev_byte_t regRdData,
   output      logic               regRdValid,
   // live comparator and detector levels
   input  wire logic               hostDisconnect,
   input  wire logic               busPowerValid,
   input  wire logic               sessionValidFlag,
   input  wire logic               sessionEndFlag,
   input  wire logic               idPinGrounded,
   input  wire logic               hostMode,
   input  wire phyev_pkg::phyev_cmp_t riseEnable,
   input  wire phyev_pkg::phyev_cmp_t fallEnable,
   input  wire logic [1:0]         lineState,
   // ID pin detectors
   input  wire logic               idFloating,
   input  wire logic               idResistanceConvDone,
   input  wire logic               vendorRidIntEnable,
   // accessory UART path
   input  wire logic               accessoryUartMode,
   input  wire logic               uartTxData,
   input  wire logic               dPlusRx,
   output      logic               dMinusOut,
   output      logic               dMinusOe,
   output      logic               data1Out,
   output      logic               data1Oe,
   output      logic               idPullLowDrive,
   // events toward the receive-command builder
   output      logic               comparatorEventPending,
   output      logic               altIntPulse
);
   import phyev_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   phyev_byte_t spare_q;
   phyev_byte_t spare_d;
   phyev_byte_t accCtrl_q;
   phyev_byte_t accCtrl_d;
   phyev_byte_t intEn_q;
   phyev_byte_t intEn_d;
   phyev_byte_t rdData_q;
   phyev_byte_t rdData_d;
   logic        rdValid_q;
   phyev_wop_e  spareOp;
   phyev_wop_e  accOp;
   phyev_wop_e  ienOp;
   phyev_cmp_t  liveStatus;
   logic        latchRead;
   logic        dMinusOut_q;
   logic        dMinusOe_q;
   logic        data1Out_q;
   logic        data1Oe_q;
   logic        idPullLow_q;
   logic        cmpPending_q;
   logic        altInt_q;
   logic        ridEnable;

   phyev_edge_if #(.W(5)) cmpEdges ();
   phyev_edge_if #(.W(1)) idOpenEdges ();
   phyev_edge_if #(.W(1)) ridEdges ();

   // ---------------------------------------------------------------
   // write helper
   // ---------------------------------------------------------------
   // keep masks hold unimplemented bits at zero whatever is written
   function automatic phyev_byte_t applyOp(
      input phyev_byte_t cur,
      input phyev_byte_t data,
      input phyev_wop_e  op,
      input phyev_byte_t keep
   );
      phyev_byte_t res;
      res = cur;
      unique case (op)
         PHYEV_WOP_NONE:  res = cur;
         PHYEV_WOP_WRITE: res = data;
         PHYEV_WOP_SET:   res = cur | data;
         PHYEV_WOP_CLEAR: res = cur & ~data;
      endcase
      return res & keep;
   endfunction

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // one decode per register family; writes to read-only addresses
   // fall through as no operation
   always_comb begin
      spareOp = PHYEV_WOP_NONE;
      accOp   = PHYEV_WOP_NONE;
      ienOp   = PHYEV_WOP_NONE;
      if (regWrStrobe) begin
         unique case (regAddr)
            `PHYEV_ADDR_SPARE_WR:  spareOp = PHYEV_WOP_WRITE;
            `PHYEV_ADDR_SPARE_SET: spareOp = PHYEV_WOP_SET;
            `PHYEV_ADDR_SPARE_CLR: spareOp = PHYEV_WOP_CLEAR;
            `PHYEV_ADDR_ACC_WR:    accOp   = PHYEV_WOP_WRITE;
            `PHYEV_ADDR_ACC_SET:   accOp   = PHYEV_WOP_SET;
            `PHYEV_ADDR_ACC_CLR:   accOp   = PHYEV_WOP_CLEAR;
            `PHYEV_ADDR_IEN_WR:    ienOp   = PHYEV_WOP_WRITE;
            `PHYEV_ADDR_IEN_SET:   ienOp   = PHYEV_WOP_SET;
            `PHYEV_ADDR_IEN_CLR:   ienOp   = PHYEV_WOP_CLEAR;
            default: begin
               spareOp = PHYEV_WOP_NONE;   // latch write ignored too
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   // spare byte: storage only, nothing downstream reads it
   always_comb begin
      spare_d = applyOp(spare_q, regWrData, spareOp,
                        `PHYEV_SPARE_KEEP);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         spare_q <= `PHYEV_SPARE_RESET;
      end else begin
         spare_q <= spare_d;
      end
   end

   // accessory control: bit 0 and bits 7:4 stay zero
   always_comb begin
      accCtrl_d = applyOp(accCtrl_q, regWrData, accOp,
                          `PHYEV_ACC_KEEP);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         accCtrl_q <= `PHYEV_ACC_RESET;
      end else begin
         accCtrl_q <= accCtrl_d;
      end
   end

   // accessory interrupt enable: only bits 0, 1 and 5 exist
   always_comb begin
      intEn_d = applyOp(intEn_q, regWrData, ienOp,
                        `PHYEV_IEN_KEEP);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         intEn_q <= `PHYEV_IEN_RESET;
      end else begin
         intEn_q <= intEn_d;
      end
   end

   // ---------------------------------------------------------------
   // comparator status and event latch
   // ---------------------------------------------------------------
   // status is combinational from the comparators, so it is never a
   // stale reset value
   always_comb begin
      liveStatus = '0;
      liveStatus[`PHYEV_CMP_HOST_DISC]  = hostDisconnect & hostMode;
      liveStatus[`PHYEV_CMP_BUS_VALID]  = busPowerValid;
      liveStatus[`PHYEV_CMP_SESS_VALID] = sessionValidFlag;
      liveStatus[`PHYEV_CMP_SESS_END]   = sessionEndFlag;
      liveStatus[`PHYEV_CMP_ID_GND]     = idPinGrounded;
   end

   // disconnect edges only qualify in host mode; the raw level is
   // tracked so a mode switch alone does not fake an edge
   always_comb begin
      cmpEdges.level    = liveStatus;
      cmpEdges.level[`PHYEV_CMP_HOST_DISC] = hostDisconnect;
      cmpEdges.riseEn   = riseEnable;
      cmpEdges.fallEn   = fallEnable;
      cmpEdges.riseEn[`PHYEV_CMP_HOST_DISC] =
         riseEnable[`PHYEV_CMP_HOST_DISC] & hostMode;
      cmpEdges.fallEn[`PHYEV_CMP_HOST_DISC] =
         fallEnable[`PHYEV_CMP_HOST_DISC] & hostMode;
      cmpEdges.clearAll = latchRead;
   end

   assign latchRead = regRdStrobe && (regAddr == `PHYEV_ADDR_LATCH);

   phyev_edge_latch #(.W(5)) cmpLatch (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .edges   (cmpEdges)
   );

   // ---------------------------------------------------------------
   // ID pin detectors
   // ---------------------------------------------------------------
   // vendor copy of the resistance enable is ORed in
   assign ridEnable = intEn_q[`PHYEV_IEN_RID_DONE]
                    | vendorRidIntEnable;

   always_comb begin
      idOpenEdges.level    = idFloating;
      idOpenEdges.riseEn   = intEn_q[`PHYEV_IEN_OPEN_RISE];
      idOpenEdges.fallEn   = intEn_q[`PHYEV_IEN_OPEN_FALL];
      idOpenEdges.clearAll = 1'b0;
      ridEdges.level       = idResistanceConvDone;
      ridEdges.riseEn      = ridEnable;
      ridEdges.fallEn      = 1'b0;
      ridEdges.clearAll    = 1'b0;
   end

   phyev_edge_latch #(.W(1)) idOpenLatch (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .edges   (idOpenEdges)
   );

   phyev_edge_latch #(.W(1)) ridLatch (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .edges   (ridEdges)
   );

   // ---------------------------------------------------------------
   // event outputs
   // ---------------------------------------------------------------
   // alt interrupt is a pulse; the command builder owns any holding
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         altInt_q     <= 1'b0;
         cmpPending_q <= 1'b0;
      end else begin
         altInt_q     <= idOpenEdges.eventPulse[0]
                       | ridEdges.eventPulse[0];
         cmpPending_q <= |cmpEdges.latched;
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // data is captured at the strobe, so a latch read returns the
   // content before the clear lands
   always_comb begin
      rdData_d = `PHYEV_BYTE_ZERO;
      unique case (regAddr)
         `PHYEV_ADDR_STATUS:
            rdData_d = {3'b000, liveStatus};
         `PHYEV_ADDR_LATCH:
            rdData_d = {3'b000, cmpEdges.latched};
         `PHYEV_ADDR_DEBUG:
            rdData_d = {6'b00_0000, lineState};
         `PHYEV_ADDR_SPARE_WR,
         `PHYEV_ADDR_SPARE_SET,
         `PHYEV_ADDR_SPARE_CLR:
            rdData_d = spare_q;
         `PHYEV_ADDR_ACC_WR,
         `PHYEV_ADDR_ACC_SET,
         `PHYEV_ADDR_ACC_CLR:
            rdData_d = accCtrl_q;
         `PHYEV_ADDR_IEN_WR,
         `PHYEV_ADDR_IEN_SET,
         `PHYEV_ADDR_IEN_CLR:
            rdData_d = intEn_q;
         default: begin
            rdData_d = `PHYEV_BYTE_ZERO;  // other blocks own the rest
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdData_q  <= `PHYEV_BYTE_ZERO;
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= regRdStrobe;
         if (regRdStrobe) begin
            rdData_q <= rdData_d;
         end
      end
   end

   // ---------------------------------------------------------------
   // accessory UART routing
   // ---------------------------------------------------------------
   // routing is registered so pins come straight from flops; costs
   // one cycle of UART latency, negligible at UART rates
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dMinusOut_q <= 1'b0;
         dMinusOe_q  <= 1'b0;
         data1Out_q  <= 1'b0;
         data1Oe_q   <= 1'b0;
         idPullLow_q <= 1'b0;
      end else begin
         dMinusOut_q <= uartTxData;
         dMinusOe_q  <= accessoryUartMode
                      & accCtrl_q[`PHYEV_ACC_TX_ROUTE];
         data1Oe_q   <= accessoryUartMode;
         if (accCtrl_q[`PHYEV_ACC_RX_ROUTE]) begin
            data1Out_q <= dPlusRx;
         end else begin
            data1Out_q <= 1'b1;
         end
         idPullLow_q <= accCtrl_q[`PHYEV_ACC_ID_PULL_LOW];
      end
   end

   // ---------------------------------------------------------------
   // output drive
   // ---------------------------------------------------------------
   assign regRdData              = rdData_q;
   assign regRdValid             = rdValid_q;
   assign dMinusOut              = dMinusOut_q;
   assign dMinusOe               = dMinusOe_q;
   assign data1Out               = data1Out_q;
   assign data1Oe                = data1Oe_q;
   assign idPullLowDrive         = idPullLow_q;
   assign comparatorEventPending = cmpPending_q;
   assign altIntPulse            = altInt_q;
endmodule

// [phyev_regs_chk.sv]
`timescale 1ns/1ns

// ------------------------------------------------------------
// port checker for the event and accessory register slice
// ------------------------------------------------------------
module phyev_regs_chk (
   input wire logic                   ref_clk,
   input wire logic                   nrst,
   input wire phyev_pkg::phyev_addr_t regAddr,
   input wire phyev_pkg::phyev_byte_t regWrData,
   input wire logic                   regWrStrobe,
   input wire logic                   regRdStrobe,
   input wire phyev_pkg::phyev_byte_t regRdData,
   input wire logic                   hostDisconnect,
   input wire logic                   busPowerValid,
   input wire logic                   sessionValidFlag,
   input wire logic                   sessionEndFlag,
   input wire logic                   idPinGrounded,
   input wire logic                   hostMode,
   input wire phyev_pkg::phyev_cmp_t  riseEnable,
   input wire phyev_pkg::phyev_cmp_t  fallEnable,
   input wire logic [1:0]             lineState,
   input wire logic                   idFloating,
   input wire logic                   idResistanceConvDone,
   input wire logic                   accessoryUartMode,
   input wire logic                   uartTxData,
   input wire logic                   dPlusRx,
   input wire logic                   dMinusOut,
   input wire logic                   dMinusOe,
   input wire logic                   data1Out,
   input wire logic                   idPullLowDrive,
   input wire logic                   comparatorEventPending,
   input wire logic                   altIntPulse
);
   import phyev_pkg::*;

   // live views as a read should return them
   wire logic [7:0] statW = {3'h0, idPinGrounded, sessionEndFlag,
      sessionValidFlag, busPowerValid, hostDisconnect & hostMode};
   wire logic [7:0] lineW = {6'h00, lineState};
   wire logic [3:0] evW   = statW[4:1];
   wire logic [5:0] lvlW  = {hostMode, statW[4:0]};
   logic            armQ;
   logic [7:0]      accQ;
   logic            d1Q;
   logic            oeQ;
   logic            pullQ;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // first edge out of reset only samples, so no events there
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) armQ <= 1'b0;
      else armQ <= 1'b1;
   end

   // shadow of accessory control, only bits 3:1 stick
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         accQ <= 8'h00;
      end else if (regWrStrobe) begin
         case (regAddr)
            6'h19: accQ <= regWrData & 8'h0E;
            6'h1A: accQ <= accQ | (regWrData & 8'h0E);
            6'h1B: accQ <= accQ & ~regWrData;
            default: ;
         endcase
      end
   end

   // pins lag the control by one register stage
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         d1Q   <= 1'b0;
         oeQ   <= 1'b0;
         pullQ <= 1'b0;
      end else begin
         d1Q   <= accQ[3] ? dPlusRx : 1'b1;
         oeQ   <= accessoryUartMode & accQ[2];
         pullQ <= accQ[1];
      end
   end

   a_status_live: assert property (
      regRdStrobe && regAddr == 6'h13 |=> regRdData == $past(statW))
      else $error("status read differs from live comparators");
   a_debug_live: assert property (
      regRdStrobe && regAddr == 6'h15 |=> regRdData == $past(lineW))
      else $error("debug read differs from line state");
   a_latch_upper: assert property (
      regRdStrobe && regAddr == 6'h14 |=> regRdData[7:5] == 3'h0)
      else $error("latch upper bits not zero");
   a_event_latched: assert property (
      armQ && |((evW & ~$past(evW) & riseEnable[4:1])
         | (~evW & $past(evW) & fallEnable[4:1]))
      |-> ##[1:3] comparatorEventPending)
      else $error("enabled comparator change not latched");
   a_latch_clears: assert property (
      (regRdStrobe && regAddr == 6'h14 && $stable(lvlW))
      ##1 $stable(lvlW)[*2] |=> !comparatorEventPending)
      else $error("latch not cleared by read");
   a_rx_route: assert property (data1Out == d1Q)
      else $error("data line 1 not routed as controlled");
   a_tx_route: assert property (
      dMinusOe == oeQ && (!dMinusOe || dMinusOut == $past(uartTxData)))
      else $error("transmit route to D-minus wrong");
   a_id_pull: assert property (idPullLowDrive == pullQ)
      else $error("ID pull-low drive does not follow control");
   a_alt_cause: assert property (
      altIntPulse |-> $past(idFloating, 2) != $past(idFloating, 3)
      || ($past(idResistanceConvDone, 2)
         && !$past(idResistanceConvDone, 3)))
      else $error("alternate interrupt without cause");
   a_ien_zero: assert property (
      regRdStrobe && regAddr inside {6'h1D, 6'h1E, 6'h1F}
      |=> (regRdData & 8'hDC) == 8'h00)
      else $error("unimplemented enable bits not zero");

   c_event: cover property (comparatorEventPending ##1 regRdStrobe);
   c_alt: cover property (altIntPulse);
   c_uart: cover property (dMinusOe && !data1Out);
endmodule

bind phyev_regs phyev_regs_chk chk (.*);

// [phyev_link_model.sv]
`timescale 1ns/1ns

// ------------------------------------------------------------
// link controller model: immediate register accesses
// ------------------------------------------------------------
module phyev_link_model (
   input  wire logic                   ref_clk,
   output phyev_pkg::phyev_addr_t      regAddr,
   output phyev_pkg::phyev_byte_t      regWrData,
   output logic                        regWrStrobe,
   output logic                        regRdStrobe,
   input  wire phyev_pkg::phyev_byte_t regRdData,
   input  wire logic                   regRdValid,
   output logic                        accessoryUartMode
);
   import phyev_pkg::*;

   // idle bus from time zero
   initial begin
      regAddr           = 6'h00;
      regWrData         = 8'h00;
      regWrStrobe       = 1'b0;
      regRdStrobe       = 1'b0;
      accessoryUartMode = 1'b0;
   end

   // one write; released lines show the inverse, not the old value
   task automatic wr(input phyev_addr_t a, input phyev_byte_t d);
      @(posedge ref_clk);
      regAddr     <= a;
      regWrData   <= d;
      regWrStrobe <= 1'b1;
      @(posedge ref_clk);
      regWrStrobe <= 1'b0;
      regAddr     <= ~a;
      regWrData   <= ~d;
   endtask

   // one read; a missing answer comes back as unknown
   task automatic rd(input phyev_addr_t a, output phyev_byte_t d);
      int n;
      @(posedge ref_clk);
      regAddr     <= a;
      regRdStrobe <= 1'b1;
      @(posedge ref_clk);
      regRdStrobe <= 1'b0;
      regAddr     <= ~a;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (!regRdValid && n < 4);
      d = regRdValid ? regRdData : 8'hxx;
   endtask

   // routing enables first, accessory mode only afterwards
   task automatic enter(input phyev_byte_t routes);
      wr(6'h19, routes);
      @(posedge ref_clk);
      accessoryUartMode <= 1'b1;
   endtask
endmodule

// [phyev_regs_test.sv]
`timescale 1ns/1ns

module phyev_regs_test;
   import phyev_pkg::*;

   logic        ref_clk, nrst, regWrStrobe, regRdStrobe, regRdValid;
   phyev_addr_t regAddr;
   phyev_byte_t regWrData, regRdData;
   logic        hostDisconnect, busPowerValid, sessionValidFlag;
   logic        sessionEndFlag, idPinGrounded, hostMode;
   phyev_cmp_t  riseEnable, fallEnable;
   logic [1:0]  lineState;
   logic        idFloating, idResistanceConvDone, vendorRidIntEnable;
   logic        accessoryUartMode, uartTxData, dPlusRx, dMinusOut;
   logic        dMinusOe, data1Out, data1Oe, idPullLowDrive;
   logic        comparatorEventPending, altIntPulse, s;
   logic [11:0] tab [9];
   int          num_errors = 0;
   int          n_tests = 0;

   phyev_regs DUT (.*);
   phyev_link_model link (.*);

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // one compare, counted, reported at once
   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rdChk(input phyev_addr_t a, input phyev_byte_t e,
                        input string what);
      phyev_byte_t v;
      link.rd(a, v);
      chk(what, v, e);
   endtask

   // the pulse lasts one cycle, so look at every settled half
   task automatic waitAlt(output logic seen);
      seen = 1'b0;
      repeat (4) begin
         @(negedge ref_clk);
         seen = seen | altIntPulse;
      end
   endtask

   task automatic setLvl(input phyev_cmp_t v);
      {idPinGrounded, sessionEndFlag, sessionValidFlag} <= v[4:2];
      {busPowerValid, hostDisconnect} <= v[1:0];
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // whole run needs under two hundred cycles; this limit is generous
   initial begin
      repeat (5000) @(posedge ref_clk);
      num_errors++;
      tally_and_finish;
   end

   initial begin
      tab = '{12'h013, 12'h010, 12'h022, 12'h021, 12'h006,
              12'h004, 12'h00F, 12'h204, 12'h207};
      nrst = 1'b0;
      {idPinGrounded, sessionEndFlag, sessionValidFlag} = 3'h0;
      {busPowerValid, hostDisconnect, hostMode} = 3'h5;
      riseEnable = 5'h1F;
      fallEnable = 5'h1F;
      lineState = 2'h0;
      {idFloating, idResistanceConvDone, vendorRidIntEnable} = 3'h0;
      {uartTxData, dPlusRx} = 2'h3;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      // spare byte: reset value, write, set, clear, no side effect
      rdChk(6'h16, 8'h00, "spare reset");
      link.wr(6'h16, 8'hA5);
      link.wr(6'h17, 8'h0A);
      link.wr(6'h18, 8'h21);
      rdChk(6'h17, 8'h8E, "spare set clear");
      chk("spare pins", {dMinusOe, data1Oe, idPullLowDrive}, 8'h00);
      link.wr(6'h13, 8'hFF);
      rdChk(6'h13, 8'h02, "status idle");
      $display("test spare done");
      // one comparator at a time, enabled edges latched; masked rise and non-host disconnect edges not latched
      for (int i = 0; i < 5; i++) begin
         setLvl(5'h01 << i);
         rdChk(6'h13, 8'h01 << i, "status bit");
      end
      rdChk(6'h14, 8'h1F, "latch all");
      rdChk(6'h14, 8'h00, "latch cleared");
      hostMode <= 1'b0;
      setLvl(5'h01);
      rdChk(6'h13, 8'h00, "disconnect outside host");
      rdChk(6'h14, 8'h10, "latch outside host");
      hostMode <= 1'b1;
      setLvl(5'h00);
      rdChk(6'h14, 8'h01, "host fall");
      riseEnable <= 5'h1B;
      setLvl(5'h04);
      rdChk(6'h14, 8'h00, "masked rise");
      setLvl(5'h00);
      repeat (3) @(negedge ref_clk);
      chk("pending", {7'h00, comparatorEventPending}, 8'h01);
      link.wr(6'h14, 8'h00);
      rdChk(6'h14, 8'h04, "enabled fall");
      $display("test comparators done");
      for (int i = 0; i < 4; i++) begin
         lineState <= i[1:0];
         rdChk(6'h15, i[7:0], "debug");
      end
      $display("test debug done");
      // accessory control, routing and pins
      link.wr(6'h19, 8'hFF);
      rdChk(6'h1B, 8'h0E, "acc write");
      chk("id pull", {7'h00, idPullLowDrive}, 8'h01);
      link.wr(6'h1B, 8'h08);
      rdChk(6'h1A, 8'h06, "acc clear");
      link.enter(8'h04);
      uartTxData <= 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("uart pins", {dMinusOe, dMinusOut, data1Oe, data1Out},
          8'h0B);
      link.wr(6'h1A, 8'h08);
      dPlusRx <= 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("rx route", {7'h00, data1Out}, 8'h00);
      $display("test accessory done");
      // interrupt enables: kept bits, float edges, conversion done
      link.wr(6'h1D, 8'hFF);
      rdChk(6'h1F, 8'h23, "ien keep");
      link.wr(6'h1F, 8'h03);
      link.wr(6'h1E, 8'h10);
      rdChk(6'h1E, 8'h20, "ien set clear");
      for (int i = 0; i < 9; i++) begin
         link.wr(6'h1D, tab[i][11:4]);
         vendorRidIntEnable <= tab[i][3];
         if (tab[i][2]) idResistanceConvDone <= tab[i][1];
         else idFloating <= tab[i][1];
         waitAlt(s);
         chk("alt int", {7'h00, s}, {7'h00, tab[i][0]});
      end
      $display("test interrupt enable done");
      tally_and_finish;
   end
endmodule
